// ### rtl/asr_pkg.sv
// package of constants and carrier types for the async serial receiver/transmitter
package asr_pkg;
    localparam int unsigned ASR_TICKS_PER_BIT = 16;
    localparam int unsigned ASR_MID_BIT = 8;
    localparam logic [3:0] ASR_TICK_LAST = 4'hF;
    localparam logic [3:0] ASR_TICK_MID = 4'h7;
    localparam logic [3:0] ASR_WLEN_BASE = 4'h5;
    localparam logic [7:0] ASR_RX_DATA_RST = 8'h00;
    localparam logic [31:0] ASR_REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] ASR_REG_TXDATA = 32'h0000_0004;
    localparam logic [31:0] ASR_REG_RXDATA = 32'h0000_0008;
    localparam logic [31:0] ASR_REG_STATUS = 32'h0000_000C;
    localparam int unsigned ASR_CTRL_WLS_LO = 0;
    localparam int unsigned ASR_CTRL_WLS_HI = 1;
    localparam int unsigned ASR_CTRL_PEVEN = 2;
    localparam int unsigned ASR_CTRL_PINH = 3;
    localparam int unsigned ASR_CTRL_STOP2 = 4;
    localparam int unsigned ASR_CTRL_CRL = 5;
    localparam int unsigned ASR_CTRL_ROD = 6;
    localparam int unsigned ASR_CTRL_SFD = 7;
    localparam int unsigned ASR_CTRL_MR = 8;
    localparam int unsigned ASR_TX_LOAD = 8;
    localparam logic [8:0] ASR_CTRL_RST = 9'h020;
    localparam logic [8:0] ASR_TXDATA_RST = 9'h100;

    typedef struct packed {
        logic word_length_sel_lo;
        logic word_length_sel_hi;
        logic parity_even_select;
        logic parity_inhibit;
        logic stop_count_select;
    } asr_cfg_s;

    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_flag;
        logic data_available;
        logic transmit_buffer_empty;
    } asr_flags_s;

    typedef enum logic [1:0] {ASR_IDLE, ASR_DATA, ASR_PAR, ASR_STOP} asr_st_e;
endpackage : asr_pkg

// ### rtl/asr_uart.sv
// async serial receiver/transmitter with AHB-Lite pin-model registers
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module asr_uart (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic transmit_clock,
    input wire logic receive_clock,
    input wire logic serial_in,
    output logic serial_out,
    output logic transmit_shifter_empty,
    output asr_pkg::asr_flags_s flags_out,
    output logic [4:0] flags_oe_n,
    output logic [7:0] receive_parallel_out,
    output logic [7:0] receive_out_oe_n
);
    import asr_pkg::*;

    // ************************************************************
    // bus slave
    // ************************************************************
    logic ap_wr_r, ap_rd_r;
    logic [3:0] ap_addr_r;
    logic [8:0] ctrl_r;
    logic [8:0] txw_r;
    logic [31:0] rdata_nxt;
    asr_cfg_s cfg_r;
    asr_flags_s flg;
    logic tx_ld_n, crl_cmd, receive_output_disable, flag_output_disable, mr;
    logic tsh_empty_r;
    logic [7:0] rx_buf_r;
    logic drr_n;
    wire ap_go = hsel && hready && htrans[1];
    // only the low sixteen bytes decode; anything above reads zero and drops writes
    wire ap_hit = (haddr[31:4] == 28'h0000000);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_rd_r <= 1'b0;
            ap_addr_r <= 4'h0;
        end else begin
            ap_wr_r <= ap_go && ap_hit && hwrite;
            ap_rd_r <= ap_go && ap_hit && !hwrite;
            ap_addr_r <= haddr[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= ASR_CTRL_RST;
            txw_r <= ASR_TXDATA_RST;
        end else if (ap_wr_r && ap_addr_r == ASR_REG_CTRL[3:0]) begin
            ctrl_r <= hwdata[8:0];
        end else if (ap_wr_r && ap_addr_r == ASR_REG_TXDATA[3:0]) begin
            txw_r <= hwdata[8:0];
        end
    end

    assign tx_ld_n = txw_r[ASR_TX_LOAD];
    assign crl_cmd = ctrl_r[ASR_CTRL_CRL];
    assign receive_output_disable = ctrl_r[ASR_CTRL_ROD];
    assign flag_output_disable = ctrl_r[ASR_CTRL_SFD];
    assign mr = ctrl_r[ASR_CTRL_MR];

    // decoded from the live address phase
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (haddr[3:0])
            ASR_REG_CTRL[3:0]: rdata_nxt = {23'h000000, ctrl_r};
            ASR_REG_TXDATA[3:0]: rdata_nxt = {23'h000000, txw_r};
            ASR_REG_RXDATA[3:0]: rdata_nxt = {24'h000000, rx_buf_r};
            ASR_REG_STATUS[3:0]: rdata_nxt = {26'h0000000, tsh_empty_r, flg};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // loaded at the address phase edge so the word stands through the data phase;
    // a write or flag change landing on that same edge is not yet seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= (ap_go && ap_hit && !hwrite) ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ************************************************************
    // control latch and synchronisers
    // ************************************************************
    // latch while strobe high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= '0;
        end else if (crl_cmd) begin
            cfg_r <= {ctrl_r[ASR_CTRL_WLS_LO], ctrl_r[ASR_CTRL_WLS_HI],
                ctrl_r[ASR_CTRL_PEVEN], ctrl_r[ASR_CTRL_PINH], ctrl_r[ASR_CTRL_STOP2]};
        end
    end

    logic [2:0] s1_r, s2_r;
    logic tck_d_r, rck_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            tck_d_r <= 1'b1;
            rck_d_r <= 1'b1;
        end else begin
            s1_r <= {transmit_clock, receive_clock, serial_in};
            s2_r <= s1_r;
            tck_d_r <= s2_r[2];
            rck_d_r <= s2_r[1];
        end
    end
    // a tick is a rising edge of a synchronised bit clock; each half period
    // of that clock must span several hclk cycles or ticks are lost
    wire t_tick = s2_r[2] && !tck_d_r;
    wire r_tick = s2_r[1] && !rck_d_r;
    wire rx_line = s2_r[0];

    wire [3:0] wlen = ASR_WLEN_BASE + {2'b00, cfg_r.word_length_sel_hi,
        cfg_r.word_length_sel_lo};
    // keeps only the configured low-order bits of a word
    wire [7:0] wmask = 8'hFF >> (4'h8 - wlen);

    // ************************************************************
    // transmitter
    // ************************************************************
    logic [7:0] thr_r, tsr_r;
    logic tbuf_full_r, tld_d_r, pend_r;
    asr_st_e tst_r;
    logic [3:0] ttk_r, tbit_r;
    logic tpar_r, tout_r, tbe_r;
    wire tx_idle = (tst_r == ASR_IDLE);
    wire tld_rise = tx_ld_n && !tld_d_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_r <= 8'h00;
            tld_d_r <= 1'b1;
        end else if (mr) begin
            thr_r <= 8'h00;
            tld_d_r <= 1'b1;
        end else begin
            tld_d_r <= tx_ld_n;
            if (!tx_ld_n) begin
                thr_r <= txw_r[7:0] & wmask;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tst_r <= ASR_IDLE;
            pend_r <= 1'b0;
            tsr_r <= 8'h00;
            ttk_r <= 4'h0;
            tbit_r <= 4'h0;
            tpar_r <= 1'b0;
            tout_r <= 1'b1;
            tsh_empty_r <= 1'b1;
        end else if (mr) begin
            tst_r <= ASR_IDLE;
            pend_r <= 1'b0;
            tout_r <= 1'b1;
            tsh_empty_r <= 1'b1;
            ttk_r <= 4'h0;
        end else begin
            if (tld_rise) begin
                pend_r <= 1'b1;
            end
            // the move waits for a tick after the strobe edge, so buffer-empty drops first
            if (tx_idle && pend_r && t_tick) begin
                pend_r <= 1'b0;
                tsr_r <= thr_r;
                tpar_r <= ~cfg_r.parity_even_select;
                tout_r <= 1'b0;
                tsh_empty_r <= 1'b0;
                tbit_r <= 4'h0;
                ttk_r <= 4'h0;
                tst_r <= ASR_DATA;
            end else if (!tx_idle && t_tick) begin
                ttk_r <= ttk_r + 4'h1;
                if (ttk_r == ASR_TICK_LAST) begin
                    case (tst_r)
                        ASR_DATA: begin
                            if (tbit_r == wlen) begin
                                tst_r <= cfg_r.parity_inhibit ? ASR_STOP : ASR_PAR;
                                tout_r <= cfg_r.parity_inhibit ? 1'b1 : tpar_r;
                                tbit_r <= 4'h0;
                            end else begin
                                tout_r <= tsr_r[0];
                                tpar_r <= tpar_r ^ tsr_r[0];
                                tsr_r <= tsr_r >> 1;
                                tbit_r <= tbit_r + 4'h1;
                            end
                        end
                        ASR_PAR: begin
                            tst_r <= ASR_STOP;
                            tout_r <= 1'b1;
                        end
                        ASR_STOP: begin
                            if (tbit_r == {3'h0, cfg_r.stop_count_select}) begin
                                tst_r <= ASR_IDLE;
                                tsh_empty_r <= 1'b1;
                            end else begin
                                tbit_r <= tbit_r + 4'h1;
                            end
                        end
                        default: tst_r <= ASR_IDLE;
                    endcase
                end
            end
        end
    end
    // data bit 0 goes out after the start bit: ASR_DATA counts start as step 0

    // a pulse during a character keeps the flag low until the end-of-character move
    // buffer empty low from pulse until moved
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbe_r <= 1'b1;
        end else if (mr) begin
            tbe_r <= 1'b1;
        end else if (tld_rise) begin
            tbe_r <= 1'b0;
        end else if (tx_idle && pend_r && t_tick) begin
            tbe_r <= 1'b1;
        end
    end

    assign serial_out = tout_r;
    assign transmit_shifter_empty = tsh_empty_r;

    // ************************************************************
    // receiver
    // ************************************************************
    asr_st_e rst_r;
    logic [3:0] rtk_r, rbit_r;
    logic [7:0] rsr_r;
    logic rpar_r, rline_d_r;
    logic pe_r, fe_r, oe_r, dr_r;
    wire rmid = r_tick && rtk_r == ASR_TICK_MID;

    assign drr_n = ~(ap_rd_r && ap_addr_r == ASR_REG_RXDATA[3:0]);

    // rbit of all ones marks the start-bit check at the first mid-bit
    // sampling engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_r <= ASR_IDLE;
            rtk_r <= 4'h0;
            rbit_r <= 4'h0;
            rsr_r <= 8'h00;
            rpar_r <= 1'b0;
            rline_d_r <= 1'b1;
        end else begin
            rline_d_r <= rx_line;
            if (rst_r == ASR_IDLE) begin
                rtk_r <= 4'h0;
                rbit_r <= 4'hF;
                // idle line high, fall marks start
                if (rline_d_r && !rx_line) begin
                    rst_r <= ASR_DATA;
                end
            end else if (r_tick) begin
                rtk_r <= rtk_r + 4'h1;
                if (rtk_r == ASR_TICK_MID) begin
                    case (rst_r)
                        ASR_DATA: begin
                            if (rbit_r == 4'hF) begin
                                if (rx_line) begin
                                    rst_r <= ASR_IDLE;
                                end
                                rsr_r <= 8'h00;
                                rpar_r <= ~cfg_r.parity_even_select;
                                rbit_r <= 4'h0;
                            end else begin
                                rsr_r[rbit_r[2:0]] <= rx_line;
                                rpar_r <= rpar_r ^ rx_line;
                                rbit_r <= rbit_r + 4'h1;
                                if (rbit_r + 4'h1 == wlen) begin
                                    rst_r <= cfg_r.parity_inhibit ? ASR_STOP : ASR_PAR;
                                end
                            end
                        end
                        ASR_PAR: begin
                            rpar_r <= rpar_r ^ rx_line;
                            rst_r <= ASR_STOP;
                        end
                        ASR_STOP: rst_r <= ASR_IDLE;
                        default: rst_r <= ASR_IDLE;
                    endcase
                end
            end
        end
    end

    // data and error flags land together, at the first stop sample
    wire rx_done = rmid && rst_r == ASR_STOP;

    // holding buffer kept through master reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buf_r <= ASR_RX_DATA_RST;
        end else if (rx_done) begin
            rx_buf_r <= rsr_r & wmask;
        end
    end

    // a word arriving in the reading cycle wins: data-available stays set, no overrun
    // status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            oe_r <= 1'b0;
            dr_r <= 1'b0;
        end else if (mr) begin
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            oe_r <= 1'b0;
            dr_r <= 1'b0;
        end else if (rx_done) begin
            pe_r <= !cfg_r.parity_inhibit && rpar_r;
            fe_r <= !rx_line;
            oe_r <= dr_r && drr_n;
            dr_r <= 1'b1;
        end else if (!drr_n) begin
            dr_r <= 1'b0;
        end
    end

    // ************************************************************
    // three-state outputs
    // ************************************************************
    assign flg = '{parity_error_flag: pe_r, framing_error_flag: fe_r,
        overrun_flag: oe_r, data_available: dr_r, transmit_buffer_empty: tbe_r};
    assign flags_out = flg;
    // enables are low while driven; the level above resolves the float
    // flag outputs float
    assign flags_oe_n = {5{flag_output_disable}};
    assign receive_parallel_out = rx_buf_r;
    assign receive_out_oe_n = {8{receive_output_disable}};
endmodule : asr_uart

// ### sim/asr_uart_checker.sv
// port-level assertion checker for the async serial receiver/transmitter
`timescale 1ns/1ns
module asr_uart_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic transmit_clock,
    input wire logic serial_out,
    input wire logic transmit_shifter_empty,
    input wire asr_pkg::asr_flags_s flags_out,
    input wire logic [4:0] flags_oe_n,
    input wire logic [7:0] receive_parallel_out,
    input wire logic [7:0] receive_out_oe_n
);
    import asr_pkg::*;
    logic ap_ctl;
    logic rd_rx;
    logic [8:0] ctl_w;
    logic tc_q;
    logic [7:0] lo_cnt;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ****
    // shadow of control writes and low-run tick count
    // ****
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_ctl <= 1'b0;
            rd_rx <= 1'b0;
            ctl_w <= ASR_CTRL_RST;
        end else begin
            ap_ctl <= hsel && hready && htrans[1] && hwrite && haddr == ASR_REG_CTRL;
            rd_rx <= hsel && hready && htrans[1] && !hwrite && haddr == ASR_REG_RXDATA;
            if (ap_ctl) begin
                ctl_w <= hwdata[8:0];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tc_q <= 1'b0;
            lo_cnt <= 8'h00;
        end else begin
            tc_q <= transmit_clock;
            if (serial_out) begin
                lo_cnt <= 8'h00;
            end else if (transmit_clock && !tc_q) begin
                lo_cnt <= lo_cnt + 8'h01;
            end
        end
    end
    flag_float_a:
        assert property (flags_oe_n == {5{ctl_w[ASR_CTRL_SFD]}}) else $error("flag enable wrong");
    rx_float_a:
        assert property (receive_out_oe_n == {8{ctl_w[ASR_CTRL_ROD]}}) else $error("rx enable wrong");
    mr_clear_a:
        assert property ($rose(ctl_w[ASR_CTRL_MR]) |-> ##2 (flags_out == 5'h01 && serial_out
            && transmit_shifter_empty && $stable(receive_parallel_out))) else $error("mr state");
    idle_high_a:
        assert property (transmit_shifter_empty && !ctl_w[ASR_CTRL_MR] |-> serial_out)
            else $error("idle line low");
    tre_fall_a:
        assert property ($fell(transmit_shifter_empty) |-> ##[0:2] !serial_out)
            else $error("shifter empty fell without start");
    bit_len_a:
        assert property ($rose(serial_out) && !ctl_w[ASR_CTRL_MR] |-> lo_cnt[3:0] == 4'h0
            && lo_cnt != 8'h00) else $error("bit length not 16 ticks");
    load_start_a:
        assert property ($fell(flags_out.transmit_buffer_empty) && transmit_shifter_empty
            |-> ##[1:16] $fell(serial_out)) else $error("start bit late");
    rd_clear_a:
        assert property (rd_rx |=> !flags_out.data_available) else $error("ready not cleared");
    overrun_a:
        assert property ($rose(flags_out.overrun_flag) |-> $past(flags_out.data_available))
            else $error("overrun without ready");
    rx_hold_a:
        assert property ($changed(receive_parallel_out) |-> flags_out.data_available)
            else $error("rx data changed without word");
endmodule : asr_uart_checker
bind asr_uart asr_uart_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .transmit_clock, .serial_out, .transmit_shifter_empty, .flags_out,
    .flags_oe_n, .receive_parallel_out, .receive_out_oe_n);

// ### sim/asr_remote.sv
// remote serial station model: frame sender and frame sampler
`timescale 1ns/1ns
module asr_remote (
    input wire logic bclk,
    output logic line_rx,
    input wire logic line_tx
);
    logic [23:0] cap = 24'h0;
    int cap_n = 0;
    logic done = 1'b0;
    // ****
    // sender and sampler
    // ****
    // idle line high
    initial line_rx = 1'b1;
    task automatic send(input logic [23:0] f, input int n, input int tpb);
        @(posedge bclk);
        for (int i = 0; i < n; i++) begin
            line_rx <= f[i];
            repeat (tpb) @(posedge bclk);
        end
        line_rx <= 1'b1;
    endtask : send
    always begin
        @(negedge line_tx);
        repeat (8) @(posedge bclk);
        for (int i = 0; i < cap_n; i++) begin
            cap[i] = line_tx;
            repeat (16) @(posedge bclk);
        end
        done = 1'b1;
    end
endmodule : asr_remote

// ### sim/testbench.sv
// self-checking testbench for the async serial receiver/transmitter
`timescale 1ns/1ns
module testbench;
    import asr_pkg::*;
    logic hclk = 1'b0;
    logic bclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic serial_in;
    logic serial_out;
    logic transmit_shifter_empty;
    asr_flags_s flags_out;
    logic [4:0] flags_oe_n;
    logic [7:0] receive_parallel_out;
    logic [7:0] receive_out_oe_n;
    int fails = 0;
    int samples_checked = 0;
    int n;
    logic [31:0] r;
    logic [23:0] f;
    logic [23:0] g;
    logic [4:0] c;
    logic [4:0] cfgs [4] = '{5'h00, 5'h15, 5'h0A, 5'h17};
    always #20 hclk = ~hclk;
    always #160 bclk = ~bclk;
    asr_uart i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .transmit_clock(bclk),
        .receive_clock(bclk), .serial_in, .serial_out, .transmit_shifter_empty, .flags_out,
        .flags_oe_n, .receive_parallel_out, .receive_out_oe_n);
    asr_remote i_rem (.bclk(bclk), .line_rx(serial_in), .line_tx(serial_out));
    // ****
    // helpers
    // ****
    task automatic summarize;
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rdc
    task automatic tx(input logic [7:0] d, input int k);
        i_rem.cap = 24'h0;
        i_rem.done = 1'b0;
        i_rem.cap_n = k;
        xfer(1'b1, ASR_REG_TXDATA, {24'h0, d});
        xfer(1'b1, ASR_REG_TXDATA, {23'h0, 1'b1, d});
    endtask : tx
    task automatic await_cap;
        for (int i = 0; i < 20000 && i_rem.done !== 1'b1; i++) @(posedge hclk);
        if (i_rem.done !== 1'b1) begin
            fails++;
            $display("[ERR] %0t no frame captured", $time);
        end
    endtask : await_cap
    task automatic await_start;
        for (int i = 0; i < 100 && transmit_shifter_empty !== 1'b0; i++) @(posedge hclk);
        if (transmit_shifter_empty !== 1'b0) begin
            fails++;
            $display("[ERR] %0t transmission never started", $time);
        end
    endtask : await_start
    function automatic logic [23:0] frame(input logic [7:0] d, input logic [4:0] k,
        output int len);
        logic [7:0] m;
        m = d & (8'hFF >> (3 - k[1:0]));
        frame = 24'h0;
        len = 1;
        for (int i = 0; i < 5 + k[1:0]; i++) begin
            frame[len] = m[i];
            len++;
        end
        if (!k[3]) begin
            frame[len] = k[2] ? ^m : ~^m;
            len++;
        end
        frame[len] = 1'b1;
        frame[len + 1] = k[4];
        len = len + 1 + k[4];
    endfunction : frame
    // ****
    // tests
    // ****
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(ASR_REG_STATUS, 32'h21);
        rdc(ASR_REG_CTRL, 32'h20);
        xfer(1'b1, 32'h10, 32'hFFFF_FFFF);
        rdc(32'h10, 32'h0);
        for (int k = 0; k < 4; k++) begin
            c = cfgs[k];
            xfer(1'b1, ASR_REG_CTRL, {26'h0, 1'b1, c});
            f = frame(8'hA7, c, n);
            tx(8'hA7, n);
            await_cap;
            chk({8'h0, i_rem.cap}, {8'h0, f});
            f = frame(8'h5C, c, n);
            i_rem.send(f, n, 16);
            rdc(ASR_REG_STATUS, 32'h23);
            rdc(ASR_REG_RXDATA, {24'h0, 8'h5C & (8'hFF >> (3 - c[1:0]))});
            rdc(ASR_REG_STATUS, 32'h21);
        end
        xfer(1'b1, ASR_REG_CTRL, 32'h0);
        f = frame(8'h3C, 5'h17, n);
        tx(8'h3C, n);
        await_cap;
        chk({8'h0, i_rem.cap}, {8'h0, f});
        xfer(1'b1, ASR_REG_CTRL, 32'h27);
        g = frame(8'hC5, 5'h07, n);
        f = frame(8'h3C, 5'h07, n) | (g << n);
        tx(8'h3C, 2 * n);
        await_start;
        tx(8'hC5, 2 * n);
        @(posedge hclk);
        rdc(ASR_REG_STATUS, 32'h0);
        await_cap;
        chk({8'h0, i_rem.cap}, {8'h0, f});
        f = frame(8'h96, 5'h07, n);
        f[9] = ~f[9];
        i_rem.send(f, n, 16);
        rdc(ASR_REG_STATUS, 32'h33);
        rdc(ASR_REG_RXDATA, 32'h96);
        f[9] = ~f[9];
        f[10] = 1'b0;
        i_rem.send(f, n, 16);
        rdc(ASR_REG_STATUS, 32'h2B);
        rdc(ASR_REG_RXDATA, 32'h96);
        i_rem.send(24'hFE, 8, 4);
        f = frame(8'h3A, 5'h07, n);
        i_rem.send(f, n, 16);
        rdc(ASR_REG_STATUS, 32'h23);
        rdc(ASR_REG_RXDATA, 32'h3A);
        f = frame(8'h11, 5'h07, n);
        i_rem.send(f, n, 16);
        f = frame(8'h22, 5'h07, n);
        i_rem.send(f, n, 16);
        rdc(ASR_REG_STATUS, 32'h27);
        rdc(ASR_REG_RXDATA, 32'h22);
        rdc(ASR_REG_STATUS, 32'h25);
        xfer(1'b1, ASR_REG_CTRL, 32'hE7);
        @(negedge hclk);
        chk({19'h0, flags_oe_n, receive_out_oe_n}, 32'h1FFF);
        @(posedge hclk);
        xfer(1'b1, ASR_REG_CTRL, 32'h27);
        @(negedge hclk);
        chk({19'h0, flags_oe_n, receive_out_oe_n}, 32'h0);
        @(posedge hclk);
        tx(8'h55, 1);
        await_start;
        xfer(1'b1, ASR_REG_CTRL, 32'h127);
        @(posedge hclk);
        rdc(ASR_REG_STATUS, 32'h21);
        chk({31'h0, serial_out}, 32'h1);
        chk({24'h0, receive_parallel_out}, 32'h22);
        rdc(ASR_REG_RXDATA, 32'h22);
        xfer(1'b1, ASR_REG_CTRL, 32'h27);
        summarize();
    end
    initial begin
        #3_000_000;
        fails++;
        summarize();
    end
endmodule : testbench
